/* File: verilog/io_port_pkg.sv */
package io_port_pkg;

  // ****************************************
  // address map, data-space byte addresses
  // ****************************************
  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;
  localparam logic [15:0] ADDR_FIRST_INPUT_PINS = 16'h0023;
  localparam logic [15:0] ADDR_FIRST_DIRECTION = 16'h0024;
  localparam logic [15:0] ADDR_FIRST_OUTPUT_DATA = 16'h0025;
  localparam logic [15:0] ADDR_SECOND_INPUT_PINS = 16'h0026;
  localparam logic [15:0] ADDR_SECOND_DIRECTION = 16'h0027;
  localparam logic [15:0] ADDR_SECOND_OUTPUT_DATA = 16'h0028;
  localparam logic [15:0] ADDR_CORE_CONTROL = 16'h0055;
  // short i/o instructions see data-space address minus this
  localparam logic [15:0] IO_SPACE_BASE = 16'h0020;
  localparam int IO_ADDR_W = 6;
  localparam logic [15:0] EXT_IO_START = 16'h0060;

  // ****************************************
  // port widths
  // ****************************************
  localparam int FIRST_PORT_W = 8;
  localparam int SECOND_PORT_W = 7;

  // ****************************************
  // core control fields and reset values
  // ****************************************
  localparam int CC_BROWNOUT_SLEEP_OFF = 6;
  localparam int CC_BROWNOUT_SLEEP_OFF_UNLOCK = 5;
  localparam int CC_GLOBAL_PULLUP_DISABLE = 4;
  localparam int CC_VECTOR_SELECT = 1;
  localparam int CC_VECTOR_CHANGE_ENABLE = 0;
  localparam logic [7:0] CORE_CONTROL_RESET = 8'h00;
  localparam logic [7:0] PORT_REG_RESET = 8'h00;

  // ****************************************
  // timing counts in clk_sys cycles
  // ****************************************
  localparam int VECTOR_CHANGE_WINDOW_CYC = 4;
  localparam int BROWNOUT_UNLOCK_WINDOW_CYC = 4;
  localparam int BROWNOUT_SLEEP_OFF_LIFE_CYC = 3;

  // ****************************************
  // vector change sequence states, gray from idle through armed to trail
  // ****************************************
  typedef enum logic [1:0] {
    VM_IDLE = 2'b00,
    VM_ARMED = 2'b01,
    VM_TRAIL = 2'b11
  } vector_mask_state_t;

endpackage

/* File: verilog/timed_window.sv */
`timescale 1ns/100ps
module timed_window #(
  parameter int CYCLES = 4
) (
  input wire logic clk_sys, // system clock
  input wire logic rst_b, // synchronous reset, active low
  input wire logic start, // opens or restarts the window
  input wire logic stop, // closes the window early
  output logic open_ff, // window open, cycles 1..CYCLES after start
  output logic last // final open cycle
);
  localparam int CNT_W = $clog2(CYCLES + 1);
  localparam logic [CNT_W-1:0] CNT_LOAD = CNT_W'(CYCLES - 1);

  logic [CNT_W-1:0] cnt_ff;

  assign last = open_ff && (cnt_ff == '0);

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      open_ff <= 1'b0;
      cnt_ff <= '0;
    end else if (start) begin
      open_ff <= 1'b1;
      cnt_ff <= CNT_LOAD;
    end else if (stop || last) begin
      open_ff <= 1'b0;
      cnt_ff <= '0;
    end else if (open_ff) begin
      cnt_ff <= cnt_ff - CNT_W'(1);
    end
  end

endmodule

/* File: verilog/gpio_port.sv */
`timescale 1ns/100ps
module gpio_port #(
  parameter int WIDTH = 8
) (
  input wire logic clk_sys, // system clock
  input wire logic rst_b, // synchronous reset, active low
  input wire logic pullup_disable, // global pull-up disable
  input wire logic wr_output_data, // write strobe, output data
  input wire logic wr_direction, // write strobe, direction
  input wire logic wr_input_pins, // write strobe, input pins (toggle)
  input wire logic [WIDTH-1:0] wdata, // write data
  input wire logic [WIDTH-1:0] pin_in, // pad levels
  output logic [WIDTH-1:0] pin_output_bit_ff, // output data register
  output logic [WIDTH-1:0] pin_direction_bit_ff, // direction, 1 = output
  output logic [WIDTH-1:0] pin_sample_ff, // sampled pad levels
  output logic [WIDTH-1:0] pullup_en_ff // pull-up enable per pad
);
  import io_port_pkg::*;

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      pin_output_bit_ff <= PORT_REG_RESET[WIDTH-1:0];
    end else if (wr_input_pins) begin
      // writing ones flips the output bit, zeros keep it
      pin_output_bit_ff <= pin_output_bit_ff ^ wdata;
    end else if (wr_output_data) begin
      pin_output_bit_ff <= wdata;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      pin_direction_bit_ff <= PORT_REG_RESET[WIDTH-1:0];
    end else if (wr_direction) begin
      pin_direction_bit_ff <= wdata;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      pin_sample_ff <= '0;
    end else begin
      pin_sample_ff <= pin_in;
    end
  end

  // pull-up only for inputs with output bit high, never when disabled
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      pullup_en_ff <= '0;
    end else begin
      pullup_en_ff <= ~pin_direction_bit_ff & pin_output_bit_ff
                      & {WIDTH{~pullup_disable}};
    end
  end

endmodule

/* File: verilog/io_port_and_mcu_control.sv */
`timescale 1ns/100ps
// Operation
// - control register at data 0x55, i/o 0x35, resets to zero, fixed bit layout
// - brown-out sleep off needs both bits set, then bit alone within four cycles
// - brown-out sleep off becomes effective after three cycles, clears after three
// - detector switched off only when sleep runs while sleep-off bit active
// - global pull-up disable forces every port pull-up off
// - vector select zero puts vectors at flash start, one at boot section
// - vector select changes only within four cycles after change enable write
// - interrupts masked from change enable write until after instruction following select write, else four cycles
// - automatic masking leaves the global interrupt enable flag untouched
// - change enable clears after four cycles or when select is written
// - boot lock bits block interrupts from the section without the vectors
// - registers reachable at data offset and at offset minus 0x20 in i/o space
// - extended space from 0x60 reachable only by data-space accesses
// - direction register bits set each pin direction
// - writing an input pin register toggles outputs, reads return pad levels
// - second port has seven pins, bit 7 reads zero
// - first port output data is eight bits, read/write, resets to zero
module io_port_and_mcu_control #(
  parameter logic [14:0] BOOT_BASE_SIZE0 = 15'h3800, // boot start, fuse code 0
  parameter logic [14:0] BOOT_BASE_SIZE1 = 15'h3C00, // boot start, fuse code 1
  parameter logic [14:0] BOOT_BASE_SIZE2 = 15'h3E00, // boot start, fuse code 2
  parameter logic [14:0] BOOT_BASE_SIZE3 = 15'h3F00 // boot start, fuse code 3
) (
  input wire logic clk_sys, // system clock, 10 MHz
  input wire logic rst_b, // synchronous reset, active low
  input wire logic acc_io_space, // 1 = short i/o instruction addressing
  input wire logic [io_port_pkg::ADDR_W-1:0] acc_addr, // register address
  input wire logic acc_wr, // write strobe
  input wire logic acc_rd, // read strobe
  input wire logic [io_port_pkg::DATA_W-1:0] acc_wdata, // write data
  output logic [io_port_pkg::DATA_W-1:0] acc_rdata_ff, // read data
  input wire logic [io_port_pkg::FIRST_PORT_W-1:0] first_pin_in, // first port pads
  output logic [io_port_pkg::FIRST_PORT_W-1:0] first_pad_out_ff, // first port drive value
  output logic [io_port_pkg::FIRST_PORT_W-1:0] first_pad_oe_ff, // first port drive enable
  output logic [io_port_pkg::FIRST_PORT_W-1:0] first_pullup_ff, // first port pull-ups
  input wire logic [io_port_pkg::SECOND_PORT_W-1:0] second_pin_in, // second port pads
  output logic [io_port_pkg::SECOND_PORT_W-1:0] second_pad_out_ff, // second port value
  output logic [io_port_pkg::SECOND_PORT_W-1:0] second_pad_oe_ff, // second port enable
  output logic [io_port_pkg::SECOND_PORT_W-1:0] second_pullup_ff, // second port pull-ups
  input wire logic instr_retire, // pulse, an instruction completes
  input wire logic sleep_exec, // pulse, sleep instruction executes
  input wire logic wake_event, // pulse, wake-up from sleep
  output logic brownout_detector_off_ff, // detector off for this sleep
  input wire logic exec_in_boot, // code running from boot section
  input wire logic app_lock_bit, // application-side boot lock programmed
  input wire logic boot_lock_bit, // boot-side boot lock programmed
  input wire logic [1:0] boot_size_fuses, // boot size configuration
  output logic [14:0] vector_base_ff, // interrupt vector table base
  output logic irq_block_ff, // interrupts blocked
  output logic global_pullup_disable_ff // pull-up disable bit
);
  import io_port_pkg::*;

  // ****************************************
  // helper functions
  // ****************************************

  // short i/o addresses are offset into data space; extended space unreachable
  function automatic logic [ADDR_W-1:0] data_space_addr(
    input logic io_space,
    input logic [ADDR_W-1:0] addr
  );
    logic [ADDR_W-1:0] short_addr;
    short_addr = {{(ADDR_W - IO_ADDR_W){1'b0}}, addr[IO_ADDR_W-1:0]};
    if (io_space) begin
      data_space_addr = short_addr + IO_SPACE_BASE;
    end else begin
      data_space_addr = addr;
    end
  endfunction

  function automatic logic [14:0] boot_base(input logic [1:0] fuses);
    case (fuses)
      2'h0: boot_base = BOOT_BASE_SIZE0;
      2'h1: boot_base = BOOT_BASE_SIZE1;
      2'h2: boot_base = BOOT_BASE_SIZE2;
      default: boot_base = BOOT_BASE_SIZE3;
    endcase
  endfunction

  // ****************************************
  // address decode
  // ****************************************
  logic [ADDR_W-1:0] eff_addr;
  logic wr_first_pins;
  logic wr_first_dir;
  logic wr_first_out;
  logic wr_second_pins;
  logic wr_second_dir;
  logic wr_second_out;
  logic wr_control;

  assign eff_addr = data_space_addr(acc_io_space, acc_addr);

  always_comb begin
    wr_first_pins = 1'b0;
    wr_first_dir = 1'b0;
    wr_first_out = 1'b0;
    wr_second_pins = 1'b0;
    wr_second_dir = 1'b0;
    wr_second_out = 1'b0;
    wr_control = 1'b0;
    if (!acc_wr) begin
      wr_control = 1'b0;
    end else if (eff_addr == ADDR_FIRST_INPUT_PINS) begin
      wr_first_pins = 1'b1;
    end else if (eff_addr == ADDR_FIRST_DIRECTION) begin
      wr_first_dir = 1'b1;
    end else if (eff_addr == ADDR_FIRST_OUTPUT_DATA) begin
      wr_first_out = 1'b1;
    end else if (eff_addr == ADDR_SECOND_INPUT_PINS) begin
      wr_second_pins = 1'b1;
    end else if (eff_addr == ADDR_SECOND_DIRECTION) begin
      wr_second_dir = 1'b1;
    end else if (eff_addr == ADDR_SECOND_OUTPUT_DATA) begin
      wr_second_out = 1'b1;
    end else if (eff_addr == ADDR_CORE_CONTROL) begin
      wr_control = 1'b1;
    end
  end

  // ****************************************
  // ports
  // ****************************************
  logic [FIRST_PORT_W-1:0] first_sample;
  logic [SECOND_PORT_W-1:0] second_sample;

  gpio_port #(
    .WIDTH(FIRST_PORT_W)
  ) u_first_port (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .pullup_disable(global_pullup_disable_ff),
    .wr_output_data(wr_first_out),
    .wr_direction(wr_first_dir),
    .wr_input_pins(wr_first_pins),
    .wdata(acc_wdata),
    .pin_in(first_pin_in),
    .pin_output_bit_ff(first_pad_out_ff),
    .pin_direction_bit_ff(first_pad_oe_ff),
    .pin_sample_ff(first_sample),
    .pullup_en_ff(first_pullup_ff)
  );

  // only seven bits are built; bit 7 of a write is dropped
  gpio_port #(
    .WIDTH(SECOND_PORT_W)
  ) u_second_port (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .pullup_disable(global_pullup_disable_ff),
    .wr_output_data(wr_second_out),
    .wr_direction(wr_second_dir),
    .wr_input_pins(wr_second_pins),
    .wdata(acc_wdata[SECOND_PORT_W-1:0]),
    .pin_in(second_pin_in),
    .pin_output_bit_ff(second_pad_out_ff),
    .pin_direction_bit_ff(second_pad_oe_ff),
    .pin_sample_ff(second_sample),
    .pullup_en_ff(second_pullup_ff)
  );

  // ****************************************
  // pull-up disable
  // ****************************************
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      global_pullup_disable_ff <= CORE_CONTROL_RESET[CC_GLOBAL_PULLUP_DISABLE];
    end else if (wr_control) begin
      global_pullup_disable_ff <= acc_wdata[CC_GLOBAL_PULLUP_DISABLE];
    end
  end

  // ****************************************
  // interrupt vector placement
  // ****************************************
  logic vec_arm;
  logic vec_select_wr;
  logic vec_change_open;
  logic vec_change_last;
  logic vector_select_ff;

  assign vec_arm = wr_control && acc_wdata[CC_VECTOR_CHANGE_ENABLE];
  // a select write with change enable low is honoured only inside the window
  assign vec_select_wr = wr_control && !acc_wdata[CC_VECTOR_CHANGE_ENABLE]
                         && vec_change_open;

  timed_window #(
    .CYCLES(VECTOR_CHANGE_WINDOW_CYC)
  ) u_vec_window (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .start(vec_arm),
    .stop(vec_select_wr),
    .open_ff(vec_change_open),
    .last(vec_change_last)
  );

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      vector_select_ff <= CORE_CONTROL_RESET[CC_VECTOR_SELECT];
    end else if (vec_select_wr) begin
      vector_select_ff <= acc_wdata[CC_VECTOR_SELECT];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      vector_base_ff <= '0;
    end else if (vector_select_ff) begin
      vector_base_ff <= boot_base(boot_size_fuses);
    end else begin
      vector_base_ff <= '0;
    end
  end

  // ****************************************
  // interrupt masking during the vector change
  // ****************************************
  vector_mask_state_t vm_state_ff;
  vector_mask_state_t nxt_vm_state;
  logic lock_block;

  always_comb begin
    nxt_vm_state = vm_state_ff;
    case (vm_state_ff)
      VM_IDLE: begin
        if (vec_arm) begin
          nxt_vm_state = VM_ARMED;
        end
      end
      VM_ARMED: begin
        if (vec_select_wr) begin
          nxt_vm_state = VM_TRAIL;
        end else if (vec_arm) begin
          nxt_vm_state = VM_ARMED;
        end else if (vec_change_last || !vec_change_open) begin
          nxt_vm_state = VM_IDLE;
        end
      end
      VM_TRAIL: begin
        // hold until the instruction after the select write completes
        if (vec_arm) begin
          nxt_vm_state = VM_ARMED;
        end else if (instr_retire) begin
          nxt_vm_state = VM_IDLE;
        end
      end
      default: nxt_vm_state = VM_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      vm_state_ff <= VM_IDLE;
    end else begin
      vm_state_ff <= nxt_vm_state;
    end
  end

  assign lock_block = (vector_select_ff && app_lock_bit && !exec_in_boot)
                      || (!vector_select_ff && boot_lock_bit && exec_in_boot);

  // separate block line; the core's global enable flag is never written here
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      irq_block_ff <= 1'b0;
    end else begin
      irq_block_ff <= (nxt_vm_state != VM_IDLE) || lock_block;
    end
  end

  // ****************************************
  // brown-out detector off during sleep
  // ****************************************
  logic bod_unlock_arm;
  logic bod_set;
  logic bod_unlock_open;
  logic bod_sleep_off_open;
  logic bod_sleep_off_active;

  assign bod_unlock_arm = wr_control && acc_wdata[CC_BROWNOUT_SLEEP_OFF]
                          && acc_wdata[CC_BROWNOUT_SLEEP_OFF_UNLOCK];
  assign bod_set = wr_control && acc_wdata[CC_BROWNOUT_SLEEP_OFF]
                   && !acc_wdata[CC_BROWNOUT_SLEEP_OFF_UNLOCK]
                   && bod_unlock_open;

  timed_window #(
    .CYCLES(BROWNOUT_UNLOCK_WINDOW_CYC)
  ) u_bod_unlock (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .start(bod_unlock_arm),
    .stop(bod_set),
    .open_ff(bod_unlock_open),
    .last()
  );

  // bit reads one for three cycles; effective only in its third
  timed_window #(
    .CYCLES(BROWNOUT_SLEEP_OFF_LIFE_CYC)
  ) u_bod_life (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .start(bod_set),
    .stop(1'b0),
    .open_ff(bod_sleep_off_open),
    .last(bod_sleep_off_active)
  );

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      brownout_detector_off_ff <= 1'b0;
    end else if (sleep_exec && bod_sleep_off_active) begin
      brownout_detector_off_ff <= 1'b1;
    end else if (wake_event) begin
      brownout_detector_off_ff <= 1'b0;
    end
  end

  // ****************************************
  // read path, one cycle latency, unmapped reads zero
  // ****************************************
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      acc_rdata_ff <= '0;
    end else if (!acc_rd) begin
      acc_rdata_ff <= acc_rdata_ff;
    end else if (eff_addr == ADDR_FIRST_INPUT_PINS) begin
      acc_rdata_ff <= first_sample;
    end else if (eff_addr == ADDR_FIRST_DIRECTION) begin
      acc_rdata_ff <= first_pad_oe_ff;
    end else if (eff_addr == ADDR_FIRST_OUTPUT_DATA) begin
      acc_rdata_ff <= first_pad_out_ff;
    end else if (eff_addr == ADDR_SECOND_INPUT_PINS) begin
      acc_rdata_ff <= {1'b0, second_sample};
    end else if (eff_addr == ADDR_SECOND_DIRECTION) begin
      acc_rdata_ff <= {1'b0, second_pad_oe_ff};
    end else if (eff_addr == ADDR_SECOND_OUTPUT_DATA) begin
      acc_rdata_ff <= {1'b0, second_pad_out_ff};
    end else if (eff_addr == ADDR_CORE_CONTROL) begin
      acc_rdata_ff <= {1'b0, bod_sleep_off_open, bod_unlock_open,
                       global_pullup_disable_ff, 2'b00,
                       vector_select_ff, vec_change_open};
    end else begin
      acc_rdata_ff <= '0;
    end
  end

endmodule

/* File: verification/pad_model.sv */
`timescale 1ns/100ps
// ****************************************
// pads and the outside circuit
// ****************************************
module pad_model #(
  parameter int WIDTH = 8
) (
  input wire logic clk_sys, // clock
  input wire logic [WIDTH-1:0] oe, // device drives pad
  input wire logic [WIDTH-1:0] drv, // device drive value
  input wire logic [WIDTH-1:0] pull, // device pull-up on
  input wire logic [WIDTH-1:0] ext_en, // outside source drives
  input wire logic [WIDTH-1:0] ext_val, // outside source value
  output logic [WIDTH-1:0] level // resolved pad level
);
  logic [WIDTH-1:0] last_ff = '0;
  always @(posedge clk_sys) last_ff <= level;
  // a floating pad wanders, so a stale value never passes
  always_comb begin
    for (int i = 0; i < WIDTH; i++) begin
      if (oe[i]) level[i] = drv[i];
      else if (ext_en[i]) level[i] = ext_val[i];
      else if (pull[i]) level[i] = 1'b1;
      else level[i] = ~last_ff[i];
    end
  end
endmodule

/* File: verification/io_port_and_mcu_control_assertions.sv */
`timescale 1ns/100ps
// ****************************************
// port, vector masking and brown-out checks
// ****************************************
module io_port_checker (
  input wire logic clk_sys, // clock
  input wire logic rst_b, // reset, low
  input wire logic acc_io_space, // i/o mode
  input wire logic [15:0] acc_addr, // address
  input wire logic acc_wr, // write strobe
  input wire logic acc_rd, // read strobe
  input wire logic [7:0] acc_wdata, // write data
  input wire logic [7:0] acc_rdata_ff, // read data
  input wire logic [7:0] first_pad_out_ff, // output data
  input wire logic [7:0] first_pad_oe_ff, // direction
  input wire logic [7:0] first_pullup_ff, // pull-ups
  input wire logic [6:0] second_pad_out_ff, // output data
  input wire logic sleep_exec, // sleep pulse
  input wire logic brownout_detector_off_ff, // detector off
  input wire logic irq_block_ff, // interrupts blocked
  input wire logic global_pullup_disable_ff // pull-up disable
);
  import io_port_pkg::*;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  wire dwr = acc_wr && !acc_io_space;
  wire drd = acc_rd && !acc_io_space && !acc_wr;
  a_output_write: assert property (
    dwr && acc_addr == ADDR_FIRST_OUTPUT_DATA |=> first_pad_out_ff == $past(acc_wdata))
    else $error("output data write lost");
  a_io_space_write: assert property (
    acc_wr && acc_io_space && acc_addr[5:0] == 6'h05 |=> first_pad_out_ff == $past(acc_wdata))
    else $error("short i/o write lost");
  a_toggle_write: assert property (
    dwr && acc_addr == ADDR_FIRST_INPUT_PINS
    |=> first_pad_out_ff == ($past(first_pad_out_ff) ^ $past(acc_wdata)))
    else $error("toggle result wrong");
  a_direction_write: assert property (
    dwr && acc_addr == ADDR_FIRST_DIRECTION |=> first_pad_oe_ff == $past(acc_wdata))
    else $error("direction write lost");
  a_output_read: assert property (
    drd && acc_addr == ADDR_FIRST_OUTPUT_DATA |=> acc_rdata_ff == $past(first_pad_out_ff))
    else $error("output data read wrong");
  a_second_top_bit: assert property (
    drd && acc_addr == ADDR_SECOND_OUTPUT_DATA
    |=> acc_rdata_ff == {1'b0, $past(second_pad_out_ff)})
    else $error("second port read wrong");
  a_pullup_gate: assert property (
    first_pullup_ff == (~$past(first_pad_oe_ff) & $past(first_pad_out_ff)
    & ~{8{$past(global_pullup_disable_ff)}}))
    else $error("pull-up enable wrong");
  a_change_mask: assert property (
    dwr && acc_addr == ADDR_CORE_CONTROL && acc_wdata[0] |-> ##[1:2] irq_block_ff)
    else $error("masking missing after arm");
  a_detector_cause: assert property (
    $rose(brownout_detector_off_ff) |-> $past(sleep_exec))
    else $error("detector off without sleep");
  c_arm: cover property (dwr && acc_addr == ADDR_CORE_CONTROL && acc_wdata[0]);
  c_toggle: cover property (dwr && acc_addr == ADDR_FIRST_INPUT_PINS);
  c_detector: cover property ($rose(brownout_detector_off_ff));
endmodule

bind io_port_and_mcu_control io_port_checker chk_i (
  .clk_sys, .rst_b, .acc_io_space, .acc_addr, .acc_wr, .acc_rd, .acc_wdata, .acc_rdata_ff,
  .first_pad_out_ff, .first_pad_oe_ff, .first_pullup_ff, .second_pad_out_ff, .sleep_exec,
  .brownout_detector_off_ff, .irq_block_ff, .global_pullup_disable_ff
);

/* File: verification/tb.sv */
`timescale 1ns/100ps
module tb;
  import io_port_pkg::*;
  // ****************************************
  // signals
  // ****************************************
  logic clk_sys = 1'b0, rst_b = 1'b0, acc_io_space = 1'b0, acc_wr = 1'b0, acc_rd = 1'b0;
  logic [15:0] acc_addr = 16'h0000;
  logic [7:0] acc_wdata = 8'h00, ext_en1 = 8'h00, ext_val1 = 8'h00;
  logic [7:0] acc_rdata_ff, first_pad_out_ff, first_pad_oe_ff, first_pullup_ff, first_lvl;
  logic [6:0] second_pad_out_ff, second_pad_oe_ff, second_pullup_ff, second_lvl;
  logic [6:0] ext_en2 = 7'h00, ext_val2 = 7'h00;
  logic instr_retire = 1'b0, sleep_exec = 1'b0, wake_event = 1'b0, exec_in_boot = 1'b0;
  logic app_lock_bit = 1'b0, boot_lock_bit = 1'b0;
  logic [1:0] boot_size_fuses = 2'h0;
  logic [14:0] vector_base_ff;
  logic brownout_detector_off_ff, irq_block_ff, global_pullup_disable_ff;
  logic [31:0] seed = 32'h49AA;
  logic [15:0] ra [6] = '{16'h0024, 16'h0025, 16'h0027, 16'h0028, 16'h0023, 16'h0026};
  logic [7:0] sh [4] = '{default: 8'h00};
  logic [7:0] v;
  int r, t, miscompares = 0, comparisons = 0;

  always #50 clk_sys = ~clk_sys;

  // arbitrary boot bases, one per fuse code
  io_port_and_mcu_control #(.BOOT_BASE_SIZE0(15'h1000), .BOOT_BASE_SIZE1(15'h1400),
    .BOOT_BASE_SIZE2(15'h1800), .BOOT_BASE_SIZE3(15'h1C00)) dut (
    .clk_sys, .rst_b, .acc_io_space, .acc_addr, .acc_wr, .acc_rd, .acc_wdata, .acc_rdata_ff,
    .first_pin_in(first_lvl), .first_pad_out_ff, .first_pad_oe_ff, .first_pullup_ff,
    .second_pin_in(second_lvl), .second_pad_out_ff, .second_pad_oe_ff, .second_pullup_ff,
    .instr_retire, .sleep_exec, .wake_event, .brownout_detector_off_ff, .exec_in_boot,
    .app_lock_bit, .boot_lock_bit, .boot_size_fuses, .vector_base_ff, .irq_block_ff,
    .global_pullup_disable_ff);
  pad_model pads1 (.clk_sys, .oe(first_pad_oe_ff), .drv(first_pad_out_ff),
    .pull(first_pullup_ff), .ext_en(ext_en1), .ext_val(ext_val1), .level(first_lvl));
  pad_model #(.WIDTH(7)) pads2 (.clk_sys, .oe(second_pad_oe_ff), .drv(second_pad_out_ff),
    .pull(second_pullup_ff), .ext_en(ext_en2), .ext_val(ext_val2), .level(second_lvl));

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic tick();
    @(posedge clk_sys);
    #1;
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // idle cycle between accesses
  task automatic acc(input logic io, input logic [15:0] a, input logic w, input logic [7:0] d);
    acc_io_space = io;
    acc_addr = io ? a - IO_SPACE_BASE : a;
    acc_wdata = d;
    acc_wr = w;
    acc_rd = !w;
    tick();
    acc_wr = 1'b0;
    acc_rd = 1'b0;
    v = acc_rdata_ff;
    tick();
  endtask
  task automatic locks(input logic sel);
    for (int i = 0; i < 8; i++) begin
      {app_lock_bit, boot_lock_bit, exec_in_boot} = i[2:0];
      repeat (2) tick();
      chk(irq_block_ff, sel ? app_lock_bit & !exec_in_boot : boot_lock_bit & exec_in_boot);
    end
    {app_lock_bit, boot_lock_bit, exec_in_boot} = 3'h0;
    tick();
  endtask
  task automatic results();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  initial begin
    repeat (5000) @(posedge clk_sys);
    miscompares++;
    results();
  end

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    repeat (2) @(posedge clk_sys);
    #1 rst_b = 1'b1;
    for (int i = 0; i < 4; i++) begin
      acc(0, ra[i], 0, 8'h00);
      chk(v, 16'h0000);
    end
    acc(1, ADDR_CORE_CONTROL, 0, 8'h00);
    chk(v, 16'h0000);
    for (int n = 0; n < 60; n++) begin
      seed = lfsr(seed);
      r = seed[2:0] % 6;
      t = (r > 3) ? r * 2 - 7 : r;
      {instr_retire, ext_en1, ext_val1} = seed[31:15];
      acc(seed[3], ra[r], 1, seed[15:8]);
      sh[t] = ((r > 3) ? sh[t] ^ seed[15:8] : seed[15:8]) & ((t > 1) ? 8'h7F : 8'hFF);
      acc(seed[4], ra[t], 0, 8'h00);
      chk(v, sh[t]);
      chk({first_pad_oe_ff, first_pad_out_ff}, {sh[0], sh[1]});
      chk({1'b0, second_pad_oe_ff, 1'b0, second_pad_out_ff}, {sh[2], sh[3]});
    end
    instr_retire = 1'b0;
    ext_en1 = 8'hFF;
    ext_en2 = 7'h7F;
    seed = lfsr(seed);
    {ext_val1, ext_val2} = seed[14:0];
    repeat (2) tick();
    acc(0, ADDR_FIRST_INPUT_PINS, 0, 8'h00);
    chk(v, (sh[0] & sh[1]) | (~sh[0] & ext_val1));
    acc(1, ADDR_SECOND_INPUT_PINS, 0, 8'h00);
    chk(v, (sh[2] & sh[3]) | (~sh[2] & {1'b0, ext_val2}));
    chk({first_pullup_ff, 1'b0, second_pullup_ff}, {~sh[0] & sh[1], ~sh[2] & sh[3]});
    acc(1, ADDR_CORE_CONTROL, 1, 8'h10);
    chk({first_pullup_ff, global_pullup_disable_ff, second_pullup_ff}, 16'h0080);
    acc(0, ADDR_CORE_CONTROL, 0, 8'h00);
    chk(v, 16'h0010);
    acc(0, EXT_IO_START, 1, 8'hFF);
    acc(1, EXT_IO_START, 1, 8'hFF);
    acc(0, EXT_IO_START, 0, 8'h00);
    chk(v, 16'h0000);
    chk({first_pad_oe_ff, first_pad_out_ff}, {sh[0], sh[1]});
    for (int f = 0; f < 4; f++) begin
      boot_size_fuses = f[1:0];
      acc(0, ADDR_CORE_CONTROL, 1, 8'h01);
      chk(irq_block_ff, 16'h0001);
      acc(1, ADDR_CORE_CONTROL, 1, 8'h02);
      chk(vector_base_ff, 15'h1000 + {f[1:0], 10'h000});
      acc(0, ADDR_CORE_CONTROL, 0, 8'h00);
      chk(v, 16'h0002);
      instr_retire = 1'b1;
      tick();
      instr_retire = 1'b0;
      repeat (3) tick();
      chk(irq_block_ff, 16'h0000);
    end
    locks(1'b1);
    // last select write lands in the fourth or the fifth cycle after arming
    for (int k = 3; k > 1; k--) begin
      acc(0, ADDR_CORE_CONTROL, 1, 8'h03);
      repeat (k) tick();
      chk(irq_block_ff, k == 2);
      acc(0, ADDR_CORE_CONTROL, 1, 8'h00);
      chk(vector_base_ff, (k == 3) ? 15'h1C00 : 15'h0000);
      chk(irq_block_ff, k == 2);
      acc(0, ADDR_CORE_CONTROL, 0, 8'h00);
      chk(v, (k == 3) ? 16'h0002 : 16'h0000);
      instr_retire = 1'b1;
      tick();
      instr_retire = 1'b0;
      repeat (3) tick();
    end
    locks(1'b0);
    for (int u = 0; u < 2; u++) begin
      for (int d = 2; d < 6; d++) begin
        acc(0, ADDR_CORE_CONTROL, 1, u ? 8'h60 : 8'h40);
        acc(0, ADDR_CORE_CONTROL, 1, 8'h40);
        repeat (d - 2) tick();
        sleep_exec = 1'b1;
        tick();
        sleep_exec = 1'b0;
        tick();
        chk(brownout_detector_off_ff, u == 1 && d == 3);
        wake_event = 1'b1;
        tick();
        wake_event = 1'b0;
        repeat (4) tick();
      end
    end
    rst_b = 1'b0;
    repeat (2) tick();
    rst_b = 1'b1;
    acc(0, ADDR_FIRST_OUTPUT_DATA, 0, 8'h00);
    chk(v, 16'h0000);
    results();
  end
endmodule
